// [shared/cic_pkg.sv]
package cic_pkg;
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL_A  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CNT_LO  = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_CNT_HI  = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_CAP_LO  = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_CAP_HI  = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_FLAGS   = 4'h6;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN  = 4'h7;
	localparam logic [ADDR_W-1:0] OFS_CMP_CS  = 4'h8;
	localparam int BIT_WGM_LO  = 0;
	localparam int BIT_CS      = 0;
	localparam int BIT_WGM_HI  = 3;
	localparam int BIT_EDGE    = 6;
	localparam int BIT_NF_EN   = 7;
	localparam int BIT_OVF     = 0;
	localparam int BIT_CAPF    = 5;
	localparam int BIT_CMP_SEL = 2;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] MAX_VAL = 16'hffff;
	localparam logic [15:0] TOP_8   = 16'h00ff;
	localparam logic [15:0] TOP_9   = 16'h01ff;
	localparam logic [15:0] TOP_10  = 16'h03ff;
	localparam int NF_SAMPLES = 4;
	localparam logic [9:0] DIV_8    = 10'h007;
	localparam logic [9:0] DIV_64   = 10'h03f;
	localparam logic [9:0] DIV_256  = 10'h0ff;
	localparam logic [9:0] DIV_1024 = 10'h3ff;
	typedef enum logic [2:0] {
		CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
	} cic_cs_t;
endpackage

// [shared/cic_trig_if.sv]
interface cic_trig_if;
	logic raw;
	logic filter_en;
	logic qualified;
	modport core (output raw, output filter_en, input qualified);
	modport filt (input raw, input filter_en, output qualified);
endinterface

// [design/cic_noise_filter.sv]
module cic_noise_filter
	import cic_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	cic_trig_if.filt trig
);
	logic [NF_SAMPLES-1:0] samples;
	logic                  out_q;

	// sampling runs on the system clock, never on the prescaled tick
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			samples <= '0;
		end else begin
			samples <= {samples[NF_SAMPLES-2:0], trig.raw};
		end
	end

	// enabled path waits for four equal samples: four cycles more than bypass
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			out_q <= 1'b0;
		end else if (!trig.filter_en) begin
			out_q <= trig.raw;
		end else if (&samples || ~|samples) begin
			out_q <= samples[0];
		end
	end
	assign trig.qualified = out_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_filter_holds: assert property (trig.filter_en && !(&samples || ~|samples)
		|=> $stable(out_q)) else $error("filter changed without four equal samples");
	a_bypass_follows: assert property (!trig.filter_en |=> out_q == $past(trig.raw))
		else $error("bypass output does not follow input");
endmodule // cic_noise_filter

// [design/cic_timer.sv]
// How it works
// - each tick counter steps up or down by one, or clears to zero.
// - top flag when count equals top, bottom flag when count is zero.
// - count in low and high byte locations; high goes via holding register.
// - reading low byte loads holding register with the counter upper byte.
// - writing low byte loads upper byte from holding register, same cycle.
// - clock select zero stops ticks; count stays readable and writable.
// - bus write to count beats clear or step in that cycle.
// - waveform mode field, split over both control registers, picks sequence.
// - overflow flag set per mode and can raise an interrupt request.
// - trigger is capture pin, or comparator output when select bit set.
// - qualifying edge copies full 16-bit count into capture register.
// - capture flag sets in the same cycle as the copy.
// - flag requests interrupt when enabled; cleared by service or writing one.
// - capture low read first loads holding register; high read returns it.
// - capture register writable only in modes using it as top.
// - changing trigger source may capture; software clears flag afterwards.
// - filter output changes only after four equal consecutive samples.
// - filter enable adds exactly four system cycles of latency.
// - filter runs on system clock, not the prescaled tick.
// - capture disabled in modes using capture register as top.
// - every new event overwrites the capture register.
module cic_timer
	import cic_pkg::*;
#(
	parameter int DATA_W = 32
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [DATA_W-1:0] avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [DATA_W-1:0] avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              capture_input_pin,
	input  wire logic              comparator_output,
	input  wire logic              external_count_pin,
	input  wire logic              overflow_irq_ack,
	input  wire logic              capture_irq_ack,
	output logic                   overflow_irq,
	output logic                   capture_irq,
	output logic                   top_hit,
	output logic                   bottom_hit
);
	logic [7:0]  timer_control_a;
	logic [7:0]  timer_control_b;
	logic [7:0]  comparator_control_status;
	logic [7:0]  irq_enable;
	logic [15:0] count_value;
	logic [15:0] capture_register;
	logic [7:0]  holding;
	logic        overflow_flag;
	logic        capture_flag;
	logic        count_down;
	logic        wait_done;
	logic [9:0]  prescale;
	logic        ext_prev;
	logic        trig_prev;
	logic        timer_tick;
	logic [3:0]  waveform_mode_field;
	logic [2:0]  clock_select_field;
	logic [15:0] top_val;
	logic        req;
	logic        first_edge;
	logic        wr_go;
	logic        rd_first;
	logic        lane0;
	logic [7:0]  wbyte;
	logic        edge_seen;
	logic        capture_go;
	logic        ovf_event;
	logic        cnt_write;
	logic [15:0] next_count;
	logic        next_down;
	logic [7:0]  rd_byte;

	cic_trig_if trig ();

	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] icr);
		case (m)
			4'h1, 4'h5: top_of = TOP_8;
			4'h2, 4'h6: top_of = TOP_9;
			4'h3, 4'h7: top_of = TOP_10;
			4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
			default: top_of = MAX_VAL;
		endcase
	endfunction

	function automatic logic uses_icr(input logic [3:0] m);
		uses_icr = (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
	endfunction

	function automatic logic dual_slope(input logic [3:0] m);
		dual_slope = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hb);
	endfunction

	function automatic logic single_top(input logic [3:0] m);
		single_top = (m >= 4'h5 && m <= 4'h7) || (m == 4'he) || (m == 4'hf);
	endfunction

	assign waveform_mode_field = {timer_control_b[BIT_WGM_HI+1:BIT_WGM_HI],
		timer_control_a[BIT_WGM_LO+1:BIT_WGM_LO]};
	assign clock_select_field = timer_control_b[BIT_CS+2:BIT_CS];
	assign top_val = top_of(waveform_mode_field, capture_register);

	// one wait state: readdata is registered on the first edge, answer on the second
	assign req = avs_read | avs_write;
	assign first_edge = req && !wait_done;
	assign avs_waitrequest = first_edge;
	assign wr_go = avs_write && wait_done;
	assign rd_first = avs_read && first_edge;
	assign lane0 = avs_byteenable[0];
	assign wbyte = avs_writedata[7:0];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wait_done <= 1'b0;
		end else begin
			wait_done <= first_edge;
		end
	end

	always_comb begin
		rd_byte = 8'h00;
		if (avs_address == OFS_CTRL_A) begin
			rd_byte = timer_control_a;
		end else if (avs_address == OFS_CTRL_B) begin
			rd_byte = timer_control_b;
		end else if (avs_address == OFS_CNT_LO) begin
			rd_byte = count_value[7:0];
		end else if (avs_address == OFS_CNT_HI || avs_address == OFS_CAP_HI) begin
			rd_byte = holding;
		end else if (avs_address == OFS_CAP_LO) begin
			rd_byte = capture_register[7:0];
		end else if (avs_address == OFS_FLAGS) begin
			rd_byte[BIT_OVF] = overflow_flag;
			rd_byte[BIT_CAPF] = capture_flag;
		end else if (avs_address == OFS_IRQ_EN) begin
			rd_byte = irq_enable;
		end else if (avs_address == OFS_CMP_CS) begin
			rd_byte = comparator_control_status;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (rd_first) begin
			avs_readdata <= {{(DATA_W-8){1'b0}}, rd_byte};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			timer_control_a <= CTRL_RST;
			timer_control_b <= CTRL_RST;
			irq_enable <= CTRL_RST;
			comparator_control_status <= CTRL_RST;
		end else if (wr_go && lane0) begin
			if (avs_address == OFS_CTRL_A) begin
				timer_control_a <= wbyte;
			end else if (avs_address == OFS_CTRL_B) begin
				timer_control_b <= wbyte;
			end else if (avs_address == OFS_IRQ_EN) begin
				irq_enable <= wbyte;
			end else if (avs_address == OFS_CMP_CS) begin
				comparator_control_status <= wbyte;
			end
		end
	end

	// holding register shared by count and capture high bytes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			holding <= 8'h00;
		end else if (rd_first && avs_address == OFS_CNT_LO) begin
			holding <= count_value[15:8];
		end else if (rd_first && avs_address == OFS_CAP_LO) begin
			holding <= capture_register[15:8];
		end else if (wr_go && lane0 &&
				(avs_address == OFS_CNT_HI || avs_address == OFS_CAP_HI)) begin
			holding <= wbyte;
		end
	end

	// prescaler free-runs; the divided ticks therefore have a random first phase
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prescale <= '0;
			ext_prev <= 1'b0;
		end else begin
			prescale <= prescale + 10'h001;
			ext_prev <= external_count_pin;
		end
	end

	always_comb begin
		case (cic_cs_t'(clock_select_field))
			CS_DIV1:     timer_tick = 1'b1;
			CS_DIV8:     timer_tick = (prescale[2:0] & DIV_8[2:0]) == DIV_8[2:0];
			CS_DIV64:    timer_tick = (prescale[5:0] & DIV_64[5:0]) == DIV_64[5:0];
			CS_DIV256:   timer_tick = (prescale[7:0] & DIV_256[7:0]) == DIV_256[7:0];
			CS_DIV1024:  timer_tick = prescale == DIV_1024;
			CS_EXT_FALL: timer_tick = ext_prev && !external_count_pin;
			CS_EXT_RISE: timer_tick = !ext_prev && external_count_pin;
			default:     timer_tick = 1'b0;
		endcase
	end

	assign top_hit = count_value == top_val;
	assign bottom_hit = count_value == 16'h0000;
	assign cnt_write = wr_go && lane0 && avs_address == OFS_CNT_LO;

	always_comb begin
		next_count = count_value;
		next_down = count_down;
		ovf_event = 1'b0;
		if (dual_slope(waveform_mode_field)) begin
			if (top_hit) begin
				next_down = 1'b1;
			end else if (bottom_hit) begin
				next_down = 1'b0;
				ovf_event = 1'b1;
			end
			next_count = next_down ? count_value - 16'h0001
				: count_value + 16'h0001;
		end else if (top_hit) begin
			next_count = 16'h0000;
			next_down = 1'b0;
			ovf_event = single_top(waveform_mode_field)
				|| count_value == MAX_VAL;
		end else begin
			next_count = count_value + 16'h0001;
			next_down = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_value <= 16'h0000;
			count_down <= 1'b0;
		end else if (cnt_write) begin
			count_value <= {holding, wbyte};
		end else if (timer_tick) begin
			count_value <= next_count;
			count_down <= next_down;
		end
	end

	// capture path: source select, filter, edge detector
	assign trig.raw = comparator_control_status[BIT_CMP_SEL]
		? comparator_output : capture_input_pin;
	assign trig.filter_en = timer_control_b[BIT_NF_EN];

	cic_noise_filter u_filter (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.trig    (trig)
	);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trig.qualified;
		end
	end

	assign edge_seen = timer_control_b[BIT_EDGE] ? (trig.qualified && !trig_prev)
		: (!trig.qualified && trig_prev);
	assign capture_go = edge_seen && !uses_icr(waveform_mode_field);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			capture_register <= 16'h0000;
		end else if (capture_go) begin
			capture_register <= count_value;
		end else if (wr_go && lane0 && avs_address == OFS_CAP_LO &&
				uses_icr(waveform_mode_field)) begin
			capture_register <= {holding, wbyte};
		end
	end

	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			capture_flag <= 1'b0;
			overflow_flag <= 1'b0;
		end else begin
			if (capture_go) begin
				capture_flag <= 1'b1;
			end else if (capture_irq_ack ||
					(wr_go && lane0 && avs_address == OFS_FLAGS && wbyte[BIT_CAPF])) begin
				capture_flag <= 1'b0;
			end
			if (timer_tick && ovf_event && !cnt_write) begin
				overflow_flag <= 1'b1;
			end else if (overflow_irq_ack ||
					(wr_go && lane0 && avs_address == OFS_FLAGS && wbyte[BIT_OVF])) begin
				overflow_flag <= 1'b0;
			end
		end
	end

	assign capture_irq = capture_flag && irq_enable[BIT_CAPF];
	assign overflow_irq = overflow_flag && irq_enable[BIT_OVF];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_low_read;
		avs_read && first_edge && avs_address == OFS_CNT_LO;
	endsequence
	sequence s_high_read;
		avs_read && first_edge && avs_address == OFS_CNT_HI;
	endsequence

	a_step_count: assert property (timer_tick && !cnt_write && !top_hit &&
		!dual_slope(waveform_mode_field) |=> count_value == $past(count_value) + 16'h0001)
		else $error("counter did not increment");
	a_stopped_hold: assert property (clock_select_field == 3'h0 && !cnt_write
		|=> $stable(count_value)) else $error("counter moved while stopped");
	a_write_wins: assert property (cnt_write |=> count_value == {$past(holding), $past(wbyte)})
		else $error("bus write did not win");
	a_coherent_read: assert property (s_low_read ##3 s_high_read
		|-> holding == $past(count_value[15:8], 3)) else $error("high byte incoherent");
	a_capture_copy: assert property (capture_go |=> capture_register == $past(count_value)
		&& capture_flag) else $error("capture copy or flag missing");
	a_icr_top_block: assert property (uses_icr(waveform_mode_field) |-> !capture_go)
		else $error("capture in icr-top mode");
	a_flag_clear: assert property (capture_irq_ack && !capture_go |=> !capture_flag)
		else $error("capture flag not cleared on service");
	a_icr_write_lock: assert property (!uses_icr(waveform_mode_field) && !capture_go
		|=> $stable(capture_register)) else $error("capture written outside top mode");
	a_irq_gate: assert property (capture_flag && irq_enable[BIT_CAPF] |-> capture_irq)
		else $error("capture irq not raised");
	a_ovf_normal: assert property (waveform_mode_field == 4'h0 && timer_tick && !cnt_write
		&& count_value == MAX_VAL |=> overflow_flag && count_value == 16'h0000)
		else $error("normal overflow wrong");
endmodule // cic_timer

// [verif/cic_event_src.sv]
module cic_event_src (
	input  wire logic ref_clk,
	input  wire logic set_pin,
	input  wire logic set_cmp,
	output logic      pin,
	output logic      cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	// levels move only just after an edge, like an already synchronised source
	always_ff @(posedge ref_clk) begin
		pin <= set_pin;
		cmp <= set_cmp;
	end
endmodule // cic_event_src

// [verif/tb_cic_timer.sv]
module tb_cic_timer
	import cic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        set_pin = 1'b0;
	logic        set_cmp = 1'b0;
	logic        pin;
	logic        cmp;
	logic        capture_irq_ack = 1'b0;
	logic        ext_pin = 1'b0;
	logic        overflow_irq;
	logic        capture_irq;
	logic        top_hit;
	logic        bottom_hit;
	logic [7:0]  q;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          n0;
	int          n1;

	always #5 ref_clk = ~ref_clk;

	cic_event_src src (.ref_clk(ref_clk), .set_pin(set_pin), .set_cmp(set_cmp), .pin(pin),
		.cmp(cmp));

	// overflow ack and byte lanes stay fixed: only lane 0 carries data
	cic_timer uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.capture_input_pin(pin), .comparator_output(cmp), .external_count_pin(ext_pin),
		.overflow_irq_ack(1'b0), .capture_irq_ack(capture_irq_ack),
		.overflow_irq(overflow_irq), .capture_irq(capture_irq), .top_hit(top_hit),
		.bottom_hit(bottom_hit));

	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// request held until the edge that follows a low waitrequest
	task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= ~w;
		forever begin
			@(negedge ref_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		@(posedge ref_clk);
		q = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		acc(a, 1'b1, d);
	endtask

	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		acc(a, 1'b0, 8'h00);
		chk("register", {8'h00, q}, {8'h00, e});
	endtask

	// high byte first, low byte commits both
	task automatic w16(input logic [3:0] lo, input logic [15:0] v);
		wr(lo + 4'h1, v[15:8]);
		wr(lo, v[7:0]);
	endtask

	task automatic r16(input logic [3:0] lo, input logic [15:0] v);
		rc(lo, v[7:0]);
		rc(lo + 4'h1, v[15:8]);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic ev(input logic p, input logic c);
		@(posedge ref_clk);
		set_pin <= p;
		set_cmp <= c;
	endtask

	// cycles from a pin change until the capture request shows
	task automatic lat(output int n);
		n = 0;
		ev(1'b1, 1'b0);
		while (capture_irq !== 1'b1 && n < 30) begin
			@(negedge ref_clk);
			n++;
		end
	endtask

	task automatic tend(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic end_sim();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		cyc(1);
		chk("bottom_hit", {15'h0, bottom_hit}, 16'h0001);
		rc(OFS_CNT_LO, 8'h00);
		tend("reset");
		w16(OFS_CNT_LO, 16'h1234);
		cyc(20);
		r16(OFS_CNT_LO, 16'h1234);
		w16(OFS_CNT_LO, 16'hffff);
		cyc(1);
		chk("top_hit", {15'h0, top_hit}, 16'h0001);
		chk("bottom_hit", {15'h0, bottom_hit}, 16'h0000);
		// external rising edges: three ticks wrap 0xffff to 0x0002
		wr(OFS_CTRL_B, 8'h07);
		repeat (3) begin
			@(posedge ref_clk);
			ext_pin <= 1'b1;
			@(posedge ref_clk);
			ext_pin <= 1'b0;
		end
		rc(OFS_CNT_LO, 8'h02);
		rc(OFS_FLAGS, 8'h01);
		tend("stopped");
		wr(OFS_CTRL_B, 8'h01);
		w16(OFS_CNT_LO, 16'h00f0);
		cyc(40);
		acc(OFS_CNT_LO, 1'b0, 8'h00);
		rc(OFS_CNT_HI, 8'h01);
		// dual slope with top 0xff: up 15, then down 5
		wr(OFS_CTRL_A, 8'h01);
		w16(OFS_CNT_LO, 16'h00f0);
		cyc(20);
		rc(OFS_CNT_LO, 8'hfa);
		wr(OFS_CTRL_A, 8'h00);
		wr(OFS_FLAGS, 8'h01);
		wr(OFS_IRQ_EN, 8'h01);
		chk("overflow_irq", {15'h0, overflow_irq}, 16'h0000);
		w16(OFS_CNT_LO, 16'hfff0);
		cyc(40);
		chk("overflow_irq", {15'h0, overflow_irq}, 16'h0001);
		rc(OFS_FLAGS, 8'h01);
		wr(OFS_FLAGS, 8'h01);
		cyc(1);
		chk("overflow_irq", {15'h0, overflow_irq}, 16'h0000);
		wr(OFS_CTRL_B, 8'h40);
		tend("count");
		w16(OFS_CNT_LO, 16'habcd);
		wr(OFS_IRQ_EN, 8'h20);
		wr(OFS_FLAGS, 8'h21);
		ev(1'b1, 1'b0);
		cyc(8);
		chk("capture_irq", {15'h0, capture_irq}, 16'h0001);
		r16(OFS_CAP_LO, 16'habcd);
		@(posedge ref_clk);
		capture_irq_ack <= 1'b1;
		@(posedge ref_clk);
		capture_irq_ack <= 1'b0;
		cyc(1);
		chk("capture_irq", {15'h0, capture_irq}, 16'h0000);
		w16(OFS_CNT_LO, 16'h1111);
		ev(1'b0, 1'b0);
		cyc(8);
		chk("capture_irq", {15'h0, capture_irq}, 16'h0000);
		wr(OFS_CTRL_B, 8'h00);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b0);
		cyc(8);
		chk("capture_irq", {15'h0, capture_irq}, 16'h0001);
		w16(OFS_CNT_LO, 16'h2222);
		wr(OFS_CMP_CS, 8'h04);
		wr(OFS_FLAGS, 8'h20);
		ev(1'b0, 1'b1);
		ev(1'b0, 1'b0);
		w16(OFS_CNT_LO, 16'h3333);
		ev(1'b0, 1'b1);
		ev(1'b0, 1'b0);
		w16(OFS_CNT_LO, 16'h4444);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b0);
		cyc(8);
		r16(OFS_CAP_LO, 16'h3333);
		wr(OFS_CMP_CS, 8'h00);
		tend("capture");
		wr(OFS_CTRL_B, 8'h40);
		wr(OFS_FLAGS, 8'h20);
		lat(n0);
		ev(1'b0, 1'b0);
		wr(OFS_CTRL_B, 8'hc0);
		cyc(8);
		wr(OFS_FLAGS, 8'h20);
		lat(n1);
		chk("filter_delay", 16'(n1 - n0), 16'h0004);
		ev(1'b0, 1'b0);
		cyc(8);
		wr(OFS_FLAGS, 8'h20);
		ev(1'b1, 1'b0);
		ev(1'b1, 1'b0);
		ev(1'b1, 1'b0);
		ev(1'b0, 1'b0);
		cyc(12);
		chk("capture_irq", {15'h0, capture_irq}, 16'h0000);
		tend("filter");
		// mode 12 uses the capture register as top, so pin events must be ignored
		wr(OFS_CTRL_B, 8'h58);
		w16(OFS_CAP_LO, 16'h5678);
		r16(OFS_CAP_LO, 16'h5678);
		wr(OFS_FLAGS, 8'h20);
		ev(1'b1, 1'b0);
		cyc(8);
		chk("capture_irq", {15'h0, capture_irq}, 16'h0000);
		r16(OFS_CAP_LO, 16'h5678);
		wr(OFS_CTRL_B, 8'h40);
		wr(OFS_CAP_LO, 8'h99);
		rc(OFS_CAP_LO, 8'h78);
		ev(1'b0, 1'b0);
		wr(4'h9, 8'h5a);
		rc(4'h9, 8'h00);
		tend("top_mode");
		end_sim();
	end

	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
endmodule // tb_cic_timer
